// file: logic/ttc_cfg.svh
// timer/trigger/event counter: offsets, field positions, timing counts
// assumes: included by the design modules
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH
`define TTC_ADDR_W 4
`define TTC_OFF_CTRL 4'h0
`define TTC_OFF_CMPA_LO 4'h1
`define TTC_OFF_CMPA_HI 4'h2
`define TTC_OFF_CAPB_LO 4'h3
`define TTC_OFF_CAPB_HI 4'h4
`define TTC_OFF_STAT 4'h5
`define TTC_OFF_CNT_LO 4'h6
`define TTC_OFF_CNT_HI 4'h7
`define TTC_OFF_TBASE 4'h8
// control register fields
`define TTC_CTRL_CK_LSB 2
`define TTC_CTRL_START_LSB 4
`define TTC_CTRL_STOPOPP_BIT 6
`define TTC_CTRL_ACAP_BIT 7
`define TTC_CTRL_MODE_LSB 0
`define TTC_CTRL_RESET 8'h00
// prescaler taps, as powers of two of mclk
`define TTC_DIV_SLOW 11
`define TTC_DIV_MID 7
`define TTC_DIV_FAST 3
`define TTC_DIV_LOWPWR 3
`define TTC_PRESC_W 12
// noise filter: reject <= 4 clocks, accept >= 8 clocks
`define TTC_FILT_REJECT 4
`define TTC_FILT_LEN 8
`endif

// file: logic/ttc_pkg.sv
// types shared by the timer/trigger/event counter
// assumes: ttc_cfg.svh on the include path
package ttc_pkg;
  typedef enum logic [1:0] {CK_SLOW, CK_MID, CK_FAST, CK_PIN} ttc_ck_t;
  typedef enum logic [1:0] {ST_STOP, ST_CMD, ST_RISE, ST_FALL} ttc_start_t;
  typedef enum logic [1:0] {MD_FAMILY, MD_WINDOW, MD_PULSE, MD_PPG} ttc_mode_t;
  typedef enum logic [1:0] {RUN_IDLE, RUN_TIMER, RUN_TRIG, RUN_EVENT} ttc_run_t;
  typedef struct packed {
    logic auto_capture_enable;
    logic stop_on_opposite_edge;
    ttc_start_t start_control_field;
    ttc_ck_t source_clock_select;
    ttc_mode_t operating_mode_field;
  } ttc_ctrl_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ttc_bus_t;
endpackage : ttc_pkg

// file: logic/ttc_prescaler.sv
// free-running prescaler producing one-cycle tick enables
// assumes: single mclk domain, synchronous reset
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_prescaler
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // tap choice
  input wire ttc_ck_t sel_i,
  input wire logic tap_sel_i,
  input wire logic low_power_i,
  // tick
  output logic tick_o
);
  typedef struct packed {
    logic [`TTC_PRESC_W-1:0] cnt;
    logic tick;
  } ttc_presc_st_t;
  ttc_presc_st_t s_q, s_d;
  logic [`TTC_PRESC_W:0] nxt;
  logic [`TTC_PRESC_W-1:0] mask;

  always_comb
  begin
    nxt = {1'b0, s_q.cnt} + {{`TTC_PRESC_W{1'b0}}, 1'b1};
    mask = {`TTC_PRESC_W{1'b1}};
    if (low_power_i)
      mask = `TTC_PRESC_W'((1 << `TTC_DIV_LOWPWR) - 1);
    else
    begin
      unique case (sel_i)
        // tap select shortens the slow tap to the low-power rate
        CK_SLOW: mask = tap_sel_i ? `TTC_PRESC_W'((1 << `TTC_DIV_LOWPWR) - 1)
                                  : `TTC_PRESC_W'((1 << `TTC_DIV_SLOW) - 1);
        CK_MID: mask = `TTC_PRESC_W'((1 << `TTC_DIV_MID) - 1);
        CK_FAST: mask = `TTC_PRESC_W'((1 << `TTC_DIV_FAST) - 1);
        CK_PIN: mask = `TTC_PRESC_W'((1 << `TTC_DIV_FAST) - 1);
      endcase
    end
    s_d.cnt = nxt[`TTC_PRESC_W-1:0];
    s_d.tick = ((s_q.cnt & mask) == mask);
  end

  always_ff @(posedge mclk_i)
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;

  assign tick_o = s_q.tick;
endmodule : ttc_prescaler

// file: logic/ttc_pin_filter.sv
// pin synchroniser, noise filter and edge detector
// assumes: asynchronous pin input, single mclk domain
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_pin_filter
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pin and filter control
  input wire logic pin_i,
  input wire logic bypass_i,
  // filtered level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] run;
    logic level;
    logic rise;
    logic fall;
  } ttc_filt_st_t;
  ttc_filt_st_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.s2 == s_q.level)
      s_d.run = 4'h0;
    else if (s_q.run != 4'hf)
      s_d.run = s_q.run + 4'h1;
    // a level must persist for TTC_FILT_LEN clocks; the bypass follows at once
    if (s_q.s2 != s_q.level && (bypass_i ||
        s_q.run >= 4'(`TTC_FILT_LEN - 1)))
    begin
      s_d.level = s_q.s2;
      s_d.rise = s_q.s2;
      s_d.fall = ~s_q.s2;
      s_d.run = 4'h0;
    end
  end

  always_ff @(posedge mclk_i)
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;

  assign level_o = s_q.level;
  assign rise_o = s_q.rise;
  assign fall_o = s_q.fall;
endmodule : ttc_pin_filter

// file: logic/ttc_timer.sv
// 16-bit timer / external-trigger timer / event counter with byte registers
// assumes: software on a plain strobe port; pin is asynchronous
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_timer
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [`TTC_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // power state
  input wire logic stop_mode_i,
  input wire logic low_power_i,
  // pin and event
  input wire logic timer_input_pin_i,
  output logic timer_match_interrupt_o
);
  typedef struct packed {
    ttc_ctrl_t ctrl;
    logic prescaler_tap_select;
    logic [7:0] cmpa_lo_stage;
    logic [15:0] cmpa_stage;
    logic cmpa_pending;
    logic [15:0] compare_reg_a;
    logic [15:0] capture_reg_b;
    logic [15:0] cnt;
    logic running;
    logic irq;
    logic match_seen;
    logic [7:0] rdata;
  } ttc_state_t;
  ttc_state_t s_q, s_d;
  logic tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic trig_edge;
  logic opp_edge;
  logic src_tick;
  logic match;
  logic [15:0] cnt_inc;
  logic match_next;
  ttc_run_t run_mode;
  ttc_bus_t bus;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  ttc_prescaler u_presc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sel_i(s_q.ctrl.source_clock_select),
    .tap_sel_i(s_q.prescaler_tap_select),
    .low_power_i(low_power_i),
    .tick_o(tick)
  );

  ttc_pin_filter u_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(timer_input_pin_i),
    .bypass_i(low_power_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  always_comb
  begin
    run_mode = RUN_IDLE;
    if (s_q.ctrl.operating_mode_field == MD_FAMILY &&
        s_q.ctrl.start_control_field != ST_STOP)
    begin
      if (s_q.ctrl.source_clock_select == CK_PIN)
        run_mode = RUN_EVENT;
      else if (s_q.ctrl.start_control_field == ST_CMD)
        run_mode = RUN_TIMER;
      else
        run_mode = RUN_TRIG;
    end
  end

  // falling-edge start codes pick the falling edge as trigger or count edge
  assign trig_edge = (s_q.ctrl.start_control_field == ST_FALL) ? pin_fall
                                                               : pin_rise;
  assign opp_edge = (s_q.ctrl.start_control_field == ST_FALL) ? pin_rise
                                                              : pin_fall;
  assign src_tick = (run_mode == RUN_EVENT) ? trig_edge : tick;
  assign match = (s_q.cnt == s_q.compare_reg_a);
  // timed modes match on the value being counted to, so a compare of n
  // gives a period of n source ticks
  assign cnt_inc = s_q.cnt + 16'h0001;
  assign match_next = (cnt_inc == s_q.compare_reg_a);

  always_comb
  begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rdata = 8'h00;
    // register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        `TTC_OFF_CTRL: s_d.ctrl = ttc_ctrl_t'(bus.wdata);
        `TTC_OFF_CMPA_LO: s_d.cmpa_lo_stage = bus.wdata;
        `TTC_OFF_CMPA_HI:
        begin
          s_d.cmpa_stage = {bus.wdata, s_q.cmpa_lo_stage};
          s_d.cmpa_pending = 1'b1;
        end
        `TTC_OFF_TBASE: s_d.prescaler_tap_select = bus.wdata[0];
        default: ;
      endcase
    end
    // register reads, data valid in the next cycle
    if (bus.rd)
    begin
      unique case (bus.addr)
        `TTC_OFF_CTRL: s_d.rdata = s_q.ctrl;
        `TTC_OFF_CMPA_LO: s_d.rdata = s_q.compare_reg_a[7:0];
        `TTC_OFF_CMPA_HI: s_d.rdata = s_q.compare_reg_a[15:8];
        `TTC_OFF_CAPB_LO: s_d.rdata = s_q.capture_reg_b[7:0];
        `TTC_OFF_CAPB_HI: s_d.rdata = s_q.capture_reg_b[15:8];
        `TTC_OFF_STAT: s_d.rdata = {5'h00, pin_level, s_q.cmpa_pending,
                                    s_q.running};
        `TTC_OFF_CNT_LO: s_d.rdata = s_q.cnt[7:0];
        `TTC_OFF_CNT_HI: s_d.rdata = s_q.cnt[15:8];
        `TTC_OFF_TBASE: s_d.rdata = {7'h00, s_q.prescaler_tap_select};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // pending compare value commits on the prescaler tick
    if (s_q.cmpa_pending && tick && !(bus.wr && bus.addr == `TTC_OFF_CMPA_HI))
    begin
      s_d.compare_reg_a = s_q.cmpa_stage;
      s_d.cmpa_pending = 1'b0;
    end

    unique case (run_mode)
      RUN_IDLE:
      begin
        s_d.cnt = 16'h0000;
        s_d.running = 1'b0;
        s_d.match_seen = 1'b0;
      end
      RUN_TIMER:
      begin
        s_d.running = 1'b1;
        if (tick)
        begin
          if (match_next)
          begin
            s_d.cnt = 16'h0000;
            s_d.irq = 1'b1;
          end
          else
            s_d.cnt = cnt_inc;
          if (s_q.ctrl.auto_capture_enable)
            s_d.capture_reg_b = s_q.cnt;
        end
      end
      RUN_TRIG:
      begin
        if (!s_q.running)
        begin
          if (trig_edge)
          begin
            s_d.running = 1'b1;
            s_d.cnt = 16'h0000;
          end
        end
        else if (s_q.ctrl.stop_on_opposite_edge && opp_edge)
        begin
          s_d.running = 1'b0;
          s_d.cnt = 16'h0000;
        end
        else if (tick) // retrigger edges fall through unused
        begin
          if (match_next)
          begin
            s_d.running = 1'b0;
            s_d.cnt = 16'h0000;
            s_d.irq = 1'b1;
          end
          else
            s_d.cnt = cnt_inc;
        end
      end
      RUN_EVENT:
      begin
        s_d.running = 1'b1;
        if (src_tick)
        begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.ctrl.auto_capture_enable)
            s_d.capture_reg_b = s_q.cnt;
        end
        else if (opp_edge && match)
        begin
          s_d.cnt = 16'h0000;
          s_d.irq = 1'b1;
        end
      end
    endcase

    // stop power mode overrides software and halts the count
    if (stop_mode_i)
    begin
      s_d.ctrl.start_control_field = ST_STOP;
      s_d.running = 1'b0;
      s_d.cnt = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i)
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;

  assign rdata_o = s_q.rdata;
  assign timer_match_interrupt_o = s_q.irq;
endmodule : ttc_timer

// file: test/ttc_timer_props.sv
// port checker for the timer/trigger/event counter
// assumes: bound to ttc_timer, one clock, sync reset
`timescale 1ns/1ps
module ttc_timer_props
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // power and event
  input wire logic stop_mode_i,
  input wire logic timer_match_interrupt_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_irq_single: assert property (timer_match_interrupt_o |=>
    !timer_match_interrupt_o) else $error("irq wider than a cycle");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !timer_match_interrupt_o && rdata_o == 8'h00)
    else $error("output active in reset");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_i && addr_i > 4'h8 |=>
    rdata_o == 8'h00) else $error("unmapped read not zero");
  a_ctrl_back: assert property (
    (wr_i && addr_i == 4'h0 && !stop_mode_i) ##1
    (rd_i && addr_i == 4'h0 && !stop_mode_i) |=>
    rdata_o == $past(wdata_i, 2)) else $error("control readback");
  a_stop_field: assert property (stop_mode_i [*2] ##0
    (rd_i && addr_i == 4'h0) |=> rdata_o[5:4] == 2'b00)
    else $error("start field kept in stop");
  a_stop_run: assert property (stop_mode_i [*2] ##0
    (rd_i && addr_i == 4'h5) |=> !rdata_o[0]) else $error("running in stop");
  a_stop_quiet: assert property (stop_mode_i [*4] |->
    !timer_match_interrupt_o) else $error("irq in stop");
endmodule : ttc_timer_props

// file: test/ttc_pulse_src.sv
// pulse source standing on the timer input pin
// assumes: called just after a rising edge of mclk_i
`timescale 1ns/1ps
module ttc_pulse_src
(
  // clock
  input wire logic mclk_i,
  // pin
  output logic pin_o
);
  initial pin_o = 1'b0;
  // levels are never shorter than two cycles
  task automatic pulse(input int hi, input int lo);
    pin_o <= 1'b1;
    repeat ((hi < 2) ? 2 : hi) @(posedge mclk_i);
    pin_o <= 1'b0;
    repeat ((lo < 2) ? 2 : lo) @(posedge mclk_i);
    #1;
  endtask : pulse
endmodule : ttc_pulse_src

// file: test/tb_timer_trigger_event_counter.sv
// self-checking bench for the timer/trigger/event counter
// assumes: ttc_timer, its port checker and the pin pulse source
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_timer_trigger_event_counter;
  typedef struct {logic tap; logic [7:0] ctrl; int per;} ttc_row_t;
  // period with compare two, per timed source clock choice and the slow tap select
  ttc_row_t rows [4] = '{'{1'b0, 8'h10, 4096}, '{1'b0, 8'h14, 256},
    '{1'b0, 8'h18, 16}, '{1'b1, 8'h10, 16}};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, stop_m = 1'b0, low_p = 1'b0;
  logic pin, irq;
  logic [7:0] rdata, c1, c2;
  int fails = 0, checked = 0, irq_cnt = 0, cycles = 0, n;
  always #4 mclk_i = ~mclk_i;
  ttc_timer dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .stop_mode_i(stop_m), .low_power_i(low_p),
    .timer_input_pin_i(pin), .timer_match_interrupt_o(irq));
  ttc_pulse_src src (.mclk_i(mclk_i), .pin_o(pin));
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic step(inout int k);
    @(posedge mclk_i);
    #1 k++;
  endtask : step
  // cycles from one interrupt to the next
  task automatic gap(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 9000) step(k);
    k = 0;
    step(k);
    while (irq !== 1'b1 && k < 9000) step(k);
  endtask : gap
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : wait_cyc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge mclk_i)
  begin
    if (irq === 1'b1)
      irq_cnt++;
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_cyc(1);
    wr_reg(4'h1, 8'h02);
    wr_reg(4'h2, 8'h00);
    foreach (rows[i])
    begin
      wr_reg(4'h8, {7'h00, rows[i].tap});
      wr_reg(4'h0, rows[i].ctrl);
      gap(n);
      `CHK("period", rows[i].per, n)
    end
    wr_reg(4'h8, 8'h00);
    wr_reg(4'h1, 8'h03);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h0, 8'h18);
    gap(n);
    `CHK("period", 24, n)
    wr_reg(4'h1, 8'h05);
    gap(n);
    gap(n);
    `CHK("low byte only", 24, n)
    wr_reg(4'h2, 8'h00);
    gap(n);
    gap(n);
    `CHK("upper byte", 40, n)
    stop_m <= 1'b1;
    wait_cyc(3);
    rd_reg(4'h0, c1);
    `CHK("start field", 2'b00, c1[5:4])
    rd_reg(4'h5, c1);
    `CHK("running", 1'b0, c1[0])
    stop_m <= 1'b0;
    irq_cnt = 0;
    wait_cyc(100);
    `CHK("stays halted", 0, irq_cnt)
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h0, 8'h98);
    wait_cyc(30);
    rd_reg(4'h3, c1);
    wait_cyc(79);
    rd_reg(4'h3, c2);
    `CHK("capture step", 8'h0a, c2 - c1)
    wr_reg(4'h0, 8'hcc);
    rd_reg(4'h0, c1);
    `CHK("control", 8'hcc, c1)
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, c1);
    `CHK("unmapped", 8'h00, c1)
    wr_reg(4'h1, 8'h0a);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h0, 8'h28);
    irq_cnt = 0;
    wait_cyc(150);
    `CHK("no trigger", 0, irq_cnt)
    src.pulse(20, 20);
    src.pulse(20, 55);
    `CHK("retrigger", 1, irq_cnt)
    wait_cyc(100);
    `CHK("halted", 1, irq_cnt)
    src.pulse(150, 10);
    `CHK("restart", 2, irq_cnt)
    wr_reg(4'h0, 8'h68);
    src.pulse(30, 150);
    `CHK("opposite stop", 2, irq_cnt)
    src.pulse(150, 10);
    `CHK("match stop", 3, irq_cnt)
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h1, 8'h03);
    wr_reg(4'h2, 8'h00);
    wait_cyc(20);
    wr_reg(4'h0, 8'h2c);
    irq_cnt = 0;
    src.pulse(20, 20);
    src.pulse(20, 20);
    `CHK("events", 0, irq_cnt)
    src.pulse(20, 20);
    `CHK("event match", 1, irq_cnt)
    src.pulse(4, 20);
    src.pulse(12, 20);
    low_p <= 1'b1;
    src.pulse(3, 20);
    rd_reg(4'h6, c1);
    `CHK("filtered count", 8'h02, c1)
    wrap_up();
  end
endmodule : tb_timer_trigger_event_counter
bind ttc_timer ttc_timer_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .stop_mode_i(stop_mode_i),
  .timer_match_interrupt_o(timer_match_interrupt_o));
